// ---- design/ccwe_pkg.sv ----
package ccwe_pkg;

  // ==========================================================================
  // Register offsets: socket memory space, then legacy index copies
  // ==========================================================================
  localparam logic [11:0] SOCK_STATUS_OFS = 12'h804;
  localparam logic [11:0] SOCK_CFG_OFS = 12'h805;
  localparam logic [11:0] SOCK_WIN_OFS = 12'h806;
  localparam logic [7:0] LEG_A_STATUS_OFS = 8'h04;
  localparam logic [7:0] LEG_A_CFG_OFS = 8'h05;
  localparam logic [7:0] LEG_A_WIN_OFS = 8'h06;
  localparam logic [7:0] LEG_B_STATUS_OFS = 8'h44;
  localparam logic [7:0] LEG_B_CFG_OFS = 8'h45;
  localparam logic [7:0] LEG_B_WIN_OFS = 8'h46;

  // ==========================================================================
  // Reset values, masks and route codes
  // ==========================================================================
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] WIN_RESET = 8'h00;
  localparam logic [7:0] WIN_WRITE_MASK = 8'hdf;
  localparam logic [3:0] FLAG_RESET = 4'h0;
  localparam logic [4:0] PINS_RESET = 5'h00;
  localparam logic [3:0] ROUTE_PCI = 4'h0;
  localparam logic [3:0] ROUTE_SMI = 4'h2;
  localparam int SYNC_STAGES = 2;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic detect_a;
    logic detect_b;
    logic ready;
    logic battery_warn;
    logic battery_dead;
  } ccwe_pins_type;

  // Bits 7:4 route, 3 detect, 2 ready, 1 warn, 0 dead
  typedef struct packed {
    logic [3:0] route;
    logic detect_en;
    logic ready_en;
    logic warn_en;
    logic dead_en;
  } ccwe_cfg_type;

  // Bit 7 io1, 6 io0, 5 reserved, 4:0 memory windows
  typedef struct packed {
    logic io1;
    logic io0;
    logic rsvd;
    logic [4:0] mem;
  } ccwe_win_type;

endpackage : ccwe_pkg

// ---- design/ccwe_sync.sv ----
`timescale 1ns/1ps
module ccwe_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // ==========================================================================
  // Two-stage synchroniser; first stage feeds only the second
  // ==========================================================================
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync;

  always_comb begin
    next_stage1 = async_i;
    next_sync = stage1;
    if (!rst_n_i) begin
      next_stage1 = '0;
      next_sync = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    stage1 <= next_stage1;
    sync_o <= next_sync;
  end

endmodule : ccwe_sync

// ---- design/ccwe_event_flags.sv ----
`timescale 1ns/1ps
module ccwe_event_flags (
  input wire logic clk_i,
  input wire logic flag_rst_i,
  input wire logic [3:0] set_i,
  input wire logic [3:0] clear_i,
  output logic [3:0] flags_o
);

  // ==========================================================================
  // Sticky flags; a set in the clearing cycle wins
  // ==========================================================================
  logic [3:0] next_flags;

  always_comb begin
    next_flags = (flags_o & ~clear_i) | set_i;
    if (flag_rst_i) begin
      next_flags = ccwe_pkg::FLAG_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    flags_o <= next_flags;
  end

endmodule : ccwe_event_flags

// ---- design/ccwe_top.sv ----
`timescale 1ns/1ps
module ccwe_top #(
  parameter bit SOCKET_B = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pci_reset_n_i,
  input wire logic pme_enable_i,
  input wire logic diag_route_pci_i,
  input wire logic socket_pci_irq_en_i,
  input wire logic flag_clear_w1c_i,
  input wire logic io_card_i,
  input wire logic card_detect_a_i,
  input wire logic card_detect_b_i,
  input wire logic card_ready_i,
  input wire logic battery_warn_i,
  input wire logic card_status_change_in_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic legacy_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [1:0] io_hit_i,
  input wire logic [4:0] mem_hit_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_hit_o,
  output logic win_claim_o,
  output logic pci_irq_o,
  output logic smi_o,
  output logic [15:0] isa_irq_o
);

  // ==========================================================================
  // Address decode
  // ==========================================================================
  function automatic logic addr_match(input logic [11:0] addr, input logic legacy,
                                      input logic [11:0] sock_ofs,
                                      input logic [7:0] leg_a_ofs,
                                      input logic [7:0] leg_b_ofs);
    logic [7:0] leg_ofs;
    leg_ofs = SOCKET_B ? leg_b_ofs : leg_a_ofs;
    return legacy ? (addr[7:0] == leg_ofs) : (addr == sock_ofs);
  endfunction : addr_match

  logic sel_status;
  logic sel_cfg;
  logic sel_win;

  always_comb begin
    sel_status = addr_match(reg_addr_i, legacy_i, ccwe_pkg::SOCK_STATUS_OFS,
                            ccwe_pkg::LEG_A_STATUS_OFS, ccwe_pkg::LEG_B_STATUS_OFS);
    sel_cfg = addr_match(reg_addr_i, legacy_i, ccwe_pkg::SOCK_CFG_OFS,
                         ccwe_pkg::LEG_A_CFG_OFS, ccwe_pkg::LEG_B_CFG_OFS);
    sel_win = addr_match(reg_addr_i, legacy_i, ccwe_pkg::SOCK_WIN_OFS,
                         ccwe_pkg::LEG_A_WIN_OFS, ccwe_pkg::LEG_B_WIN_OFS);
  end

  // ==========================================================================
  // Pin synchronisers and edge detection
  // ==========================================================================
  ccwe_pkg::ccwe_pins_type pins_s;
  ccwe_pkg::ccwe_pins_type pins_prev;
  ccwe_pkg::ccwe_pins_type next_pins_prev;
  logic pci_rst_n_s;
  logic primed;
  logic next_primed;

  ccwe_sync #(
    .WIDTH(6)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({pci_reset_n_i, card_detect_a_i, card_detect_b_i, card_ready_i,
              battery_warn_i, card_status_change_in_i}),
    .sync_o({pci_rst_n_s, pins_s})
  );

  // PCI reset is seen low for the synchroniser's fill after global reset;
  // primed holds off that window and the first sample of the pins.
  logic [1:0] fill_cnt;
  logic [1:0] next_fill_cnt;

  always_comb begin
    next_pins_prev = pins_s;
    next_fill_cnt = fill_cnt;
    if (fill_cnt != 2'(ccwe_pkg::SYNC_STAGES)) begin
      next_fill_cnt = fill_cnt + 2'h1;
    end
    next_primed = (fill_cnt == 2'(ccwe_pkg::SYNC_STAGES));
    if (!rst_n_i) begin
      next_pins_prev = ccwe_pkg::PINS_RESET;
      next_fill_cnt = 2'h0;
      next_primed = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    pins_prev <= next_pins_prev;
    fill_cnt <= next_fill_cnt;
    primed <= next_primed;
  end

  // ==========================================================================
  // Configuration and window enable registers
  // ==========================================================================
  ccwe_pkg::ccwe_cfg_type cfg;
  ccwe_pkg::ccwe_cfg_type next_cfg;
  ccwe_pkg::ccwe_win_type win;
  ccwe_pkg::ccwe_win_type next_win;
  logic pci_rst_act;
  logic en_clear;
  logic any_clear;

  always_comb begin
    pci_rst_act = primed && !pci_rst_n_s;
    any_clear = !rst_n_i || pci_rst_act;
    en_clear = !rst_n_i || (pci_rst_act && !pme_enable_i);
    next_cfg = cfg;
    next_win = win;
    if (reg_wr_i && sel_cfg) begin
      next_cfg = reg_wdata_i;
    end
    if (reg_wr_i && sel_win) begin
      next_win = reg_wdata_i & ccwe_pkg::WIN_WRITE_MASK;
    end
    if (any_clear) begin
      next_cfg.route = ccwe_pkg::CFG_RESET[7:4];
      next_win = ccwe_pkg::WIN_RESET;
    end
    if (en_clear) begin
      next_cfg[3:0] = ccwe_pkg::CFG_RESET[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    cfg <= next_cfg;
    win <= next_win;
  end

  // ==========================================================================
  // Status-change events and flags
  // ==========================================================================
  logic [3:0] enables;
  logic [3:0] events;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  logic [3:0] flags;
  logic [3:0] shown;

  always_comb begin
    enables = {cfg.detect_en, cfg.ready_en, cfg.warn_en, cfg.dead_en};
    events[3] = (pins_s.detect_a ^ pins_prev.detect_a) |
                (pins_s.detect_b ^ pins_prev.detect_b);
    events[2] = !io_card_i && pins_s.ready && !pins_prev.ready;
    events[1] = !io_card_i && pins_s.battery_warn && !pins_prev.battery_warn;
    events[0] = pins_s.battery_dead && !pins_prev.battery_dead;
    flag_set = primed ? (events & enables) : 4'h0;
    shown = flags & enables;
    flag_clr = 4'h0;
    if (sel_status && reg_rd_i && !flag_clear_w1c_i) begin
      flag_clr = shown;
    end
    if (sel_status && reg_wr_i && flag_clear_w1c_i) begin
      flag_clr = reg_wdata_i[3:0];
    end
  end

  ccwe_event_flags u_flags (
    .clk_i(clk_i),
    .flag_rst_i(en_clear),
    .set_i(flag_set),
    .clear_i(flag_clr),
    .flags_o(flags)
  );

  // ==========================================================================
  // Read data, interrupt routing and window claim
  // ==========================================================================
  logic pending;
  logic [7:0] next_rdata;
  logic next_hit;
  logic next_claim;
  logic next_pci;
  logic next_smi;
  logic [15:0] next_isa;

  always_comb begin
    pending = |shown;
    next_rdata = 8'h00;
    next_hit = reg_rd_i && (sel_status || sel_cfg || sel_win);
    if (reg_rd_i && sel_status) begin
      next_rdata = {4'h0, shown};
    end
    if (reg_rd_i && sel_cfg) begin
      next_rdata = cfg;
    end
    if (reg_rd_i && sel_win) begin
      next_rdata = win;
    end
    next_claim = |({io_hit_i, mem_hit_i} & {win.io1, win.io0, win.mem});
    next_pci = 1'b0;
    next_smi = 1'b0;
    next_isa = 16'h0000;
    if (pending) begin
      if (cfg.route == ccwe_pkg::ROUTE_PCI) begin
        next_pci = diag_route_pci_i || socket_pci_irq_en_i;
      end else if (cfg.route == ccwe_pkg::ROUTE_SMI) begin
        next_smi = 1'b1;
      end else begin
        next_isa = 16'h0001 << cfg.route;
      end
    end
    if (!rst_n_i) begin
      next_rdata = 8'h00;
      next_hit = 1'b0;
      next_claim = 1'b0;
      next_pci = 1'b0;
      next_smi = 1'b0;
      next_isa = 16'h0000;
    end
  end

  always_ff @(posedge clk_i) begin
    reg_rdata_o <= next_rdata;
    reg_hit_o <= next_hit;
    win_claim_o <= next_claim;
    pci_irq_o <= next_pci;
    smi_o <= next_smi;
    isa_irq_o <= next_isa;
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_reset_cfg_zero: assert property ($rose(rst_n_i) |-> cfg == 8'h00)
    else $error("Configuration not zero after reset");
  a_win_reset_zero: assert property (!$past(rst_n_i) |-> win == 8'h00 && !win_claim_o)
    else $error("Window enables not zero after reset");
  a_rsvd_bit_zero: assert property (reg_wr_i && sel_win |=> !win.rsvd)
    else $error("Reserved window bit became set");
  a_claim_gated: assert property (win_claim_o |-> $past(|({io_hit_i, mem_hit_i} &
                                  {win.io1, win.io0, win.mem})))
    else $error("Claimed a cycle to a disabled window");
  a_pci_diag_route: assert property (pending && cfg.route == 4'h0 && diag_route_pci_i
                                     |=> pci_irq_o)
    else $error("Diagnostic PCI route not taken");
  a_no_pci_masked: assert property (cfg.route == 4'h0 && !diag_route_pci_i &&
                                    !socket_pci_irq_en_i |=> !pci_irq_o && isa_irq_o == 16'h0)
    else $error("Route zero drove an interrupt while disabled");
  a_isa_line_route: assert property (pending && cfg.route == 4'h3 |=> isa_irq_o == 16'h0008
                                     && !smi_o)
    else $error("Route code 3 did not select IRQ3");
  a_smi_route: assert property (pending && cfg.route == 4'h2 |=> smi_o && isa_irq_o == 16'h0)
    else $error("Route code 2 did not select SMI");
  // A reset that clears the flags in the same cycle wins over the event
  a_detect_set: assert property (primed && events[3] && cfg.detect_en && !en_clear
                                 |=> flags[3])
    else $error("Card detect change not flagged");
  a_ready_set: assert property (primed && events[2] && cfg.ready_en && !en_clear
                                |=> flags[2])
    else $error("Ready rise not flagged");
  a_warn_set: assert property (primed && events[1] && cfg.warn_en && !en_clear
                               |=> flags[1])
    else $error("Battery warning not flagged");
  a_dead_set: assert property (primed && events[0] && cfg.dead_en && !en_clear
                               |=> flags[0])
    else $error("Battery dead or status change not flagged");
  a_masked_reads_zero: assert property (reg_rd_i && sel_status && !cfg.warn_en |=>
                                        !reg_rdata_o[1])
    else $error("Masked flag read as set");
  a_pme_keeps_en: assert property (pci_rst_act && pme_enable_i && !(reg_wr_i && sel_cfg)
                                   |=> cfg[3:0] == $past(cfg[3:0]))
    else $error("Enables lost on PCI reset with PME enabled");
  a_irq_drops: assert property (!pending |=> !pci_irq_o && !smi_o && isa_irq_o == 16'h0)
    else $error("Interrupt held with no pending flag");

  c_detect_irq: cover property (events[3] && cfg.detect_en ##1 flags[3] ##1 pci_irq_o);
  c_isa_route: cover property (pending && cfg.route == 4'h5 ##1 isa_irq_o[5]);
  c_read_clear: cover property (reg_rd_i && sel_status && shown != 4'h0 ##1 flags == 4'h0);
  c_claim: cover property (win_claim_o);

endmodule : ccwe_top

// ---- dv/ccwe_card_model.sv ----
`timescale 1ns/1ps
// ============================================================================
// Card socket pins: each request bit toggles its pin a little after the edge
// ============================================================================
module ccwe_card_model (
  input wire logic clk_i,
  input wire logic [4:0] ev_i,
  output ccwe_pkg::ccwe_pins_type pins_o
);
  initial pins_o = ccwe_pkg::PINS_RESET;
  always @(posedge clk_i) begin
    pins_o <= #2 pins_o ^ ev_i;
  end
endmodule : ccwe_card_model

// ---- dv/card_csc_irq_and_window_enable_tb.sv ----
`timescale 1ns/1ps
module card_csc_irq_and_window_enable_tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic pci_rst_n = 1'b1;
  logic pme = 1'b0;
  logic diag = 1'b1;
  logic sock_en = 1'b0;
  logic w1c = 1'b0;
  logic io_card = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic leg = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic [1:0] io_hit = 2'h0;
  logic [4:0] mem_hit = 5'h00;
  logic [4:0] ev = 5'h00;
  logic [7:0] rdata;
  logic hit, claim, pci_irq, smi, seen = 1'b0;
  logic [15:0] isa;
  logic [17:0] irqs;
  ccwe_pkg::ccwe_pins_type pins;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000005e;
  logic [9:0] exp_q[$];

  assign irqs = {pci_irq, smi, isa};
  always #5 clk_i = ~clk_i;

  ccwe_card_model card (.clk_i(clk_i), .ev_i(ev), .pins_o(pins));

  ccwe_top uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .pci_reset_n_i(pci_rst_n), .pme_enable_i(pme),
    .diag_route_pci_i(diag), .socket_pci_irq_en_i(sock_en), .flag_clear_w1c_i(w1c),
    .io_card_i(io_card), .card_detect_a_i(pins.detect_a), .card_detect_b_i(pins.detect_b),
    .card_ready_i(pins.ready), .battery_warn_i(pins.battery_warn),
    .card_status_change_in_i(pins.battery_dead), .reg_wr_i(wr), .reg_rd_i(rd),
    .legacy_i(leg), .reg_addr_i(addr), .reg_wdata_i(wdata), .io_hit_i(io_hit),
    .mem_hit_i(mem_hit), .reg_rdata_o(rdata), .reg_hit_o(hit), .win_claim_o(claim),
    .pci_irq_o(pci_irq), .smi_o(smi), .isa_irq_o(isa)
  );

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task check(input logic [17:0] got, input logic [17:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  task wr_reg(input logic [11:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask : wr_reg

  // Expected value is {hit, data}
  task rd_reg(input logic [11:0] a, input logic [8:0] e);
    addr = a;
    rd = 1'b1;
    exp_q.push_back({e, 1'b0});
    cyc(1);
    rd = 1'b0;
    cyc(1);
  endtask : rd_reg

  task hits(input logic [6:0] h, input logic c);
    {io_hit, mem_hit} = h;
    exp_q.push_back({9'h000, c});
    cyc(1);
    {io_hit, mem_hit} = 7'h00;
    cyc(1);
  endtask : hits

  task pulse(input logic [4:0] x);
    ev = x;
    cyc(1);
    ev = 5'h00;
    cyc(1);
  endtask : pulse

  task irq_wait(input logic [17:0] e);
    int i;
    i = 0;
    while (irqs !== e && i < 10) begin
      cyc(1);
      i++;
    end
    check(irqs, e, "irq");
  endtask : irq_wait

  task finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // ==========================================================================
  // Watcher: a register or claim result stands one cycle after its request
  // ==========================================================================
  always @(posedge clk_i) begin
    // Every read or hit request leaves a note, so an all-zero hit vector is still checked
    seen <= exp_q.size() != 0;
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      finish_test();
    end
  end

  always @(negedge clk_i) begin
    if (seen) begin
      check({hit, rdata, claim}, exp_q.size() > 0 ? exp_q.pop_front() : 10'h3ff, "bus");
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [31:0] v;
    logic [17:0] e;
    logic [3:0] r;
    cyc(6);
    rst_n_i = 1'b1;
    cyc(3);
    rd_reg(12'h805, 9'h100);
    rd_reg(12'h806, 9'h100);
    wr_reg(12'h806, 8'hff);
    rd_reg(12'h806, 9'h1df);
    for (int k = 0; k < 16; k++) begin
      v = xs();
      wr_reg(12'h806, v[7:0]);
      rd_reg(12'h806, {1'b1, v[7:0] & 8'hdf});
      hits(v[14:8], |(v[14:8] & {v[7:6], v[4:0]}));
    end
    leg = 1'b1;
    rd_reg(12'h006, {1'b1, v[7:0] & 8'hdf});
    rd_reg(12'h045, 9'h000);
    v = xs();
    wr_reg(12'h005, v[7:0]);
    leg = 1'b0;
    rd_reg(12'h805, {1'b1, v[7:0]});
    rd_reg(12'h807, 9'h000);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      w1c = i[0];
      wr_reg(12'h805, 8'h01 << (3 - i));
      pulse(i == 0 ? 5'h10 : 5'h01 << (3 - i));
      irq_wait(18'h20000);
      rd_reg(12'h804, {1'b1, 8'h01 << (3 - i)});
      if (w1c) begin
        check(irqs, 18'h20000, "w1c read kept flag");
        wr_reg(12'h804, 8'h0f);
      end
      irq_wait(18'h00000);
    end
    w1c = 1'b0;
    wr_reg(12'h805, 8'h07);
    pulse(5'h08);
    cyc(8);
    check(irqs, 18'h00000, "masked");
    rd_reg(12'h804, 9'h100);
    // I/O card: ready and warning rises are ignored, status change still counts
    io_card = 1'b1;
    wr_reg(12'h805, 8'h07);
    pulse(5'h07);
    pulse(5'h07);
    irq_wait(18'h20000);
    rd_reg(12'h804, 9'h101);
    irq_wait(18'h00000);
    io_card = 1'b0;
    $display("test events done");
    for (int k = 0; k < 18; k++) begin
      r = (k < 3) ? 4'h0 : 4'(k - 2);
      diag = (k == 2);
      sock_en = (k == 1);
      e = (k == 0) ? 18'h0 : (k < 3) ? 18'h20000 : (r == 4'h2) ? 18'h10000 : 18'h1 << r;
      wr_reg(12'h805, {r, 4'h8});
      pulse(5'h08);
      cyc(6);
      irq_wait(e);
      rd_reg(12'h804, 9'h108);
      irq_wait(18'h00000);
    end
    $display("test routing done");
    for (int k = 0; k < 3; k++) begin
      wr_reg(12'h805, 8'h3f);
      wr_reg(12'h806, 8'hc1);
      pme = (k != 1);
      if (k == 2) begin
        rst_n_i = 1'b0;
      end else begin
        pci_rst_n = 1'b0;
      end
      cyc(4);
      rst_n_i = 1'b1;
      pci_rst_n = 1'b1;
      cyc(4);
      rd_reg(12'h805, (k == 0) ? 9'h10f : 9'h100);
      rd_reg(12'h806, 9'h100);
    end
    $display("test resets done");
    finish_test();
  end
endmodule : card_csc_irq_and_window_enable_tb
